// ### vp_regs_pkg.sv
// register offsets, field layout, reset values and timing for the playback config bank
// assumes a 32-bit AHB-Lite bus with one register per aligned word (byte address = 4 * index)
package vp_regs_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_BRANCH_MASK = 8'h08;
  localparam logic [7:0] IDX_CARRIER = 8'h09;
  localparam logic [7:0] IDX_CHANNEL = 8'h0c;
  localparam logic [7:0] IDX_CHAN0_RELOAD = 8'h0d;
  localparam logic [7:0] IDX_CHAN1_RELOAD = 8'h0e;
  localparam logic [7:0] IDX_CHAN2_RELOAD = 8'h0f;
  localparam logic [7:0] IDX_CHAN_STATUS = 8'h18;

  // field positions
  localparam int BIT_BRANCH_BUSY = 6;
  localparam int CARRIER_RATE_LSB = 0;
  localparam int CARRIER_SPREAD_LSB = 3;
  localparam int BIT_TDM_OFF = 7;
  localparam int CMD_CHAN_LSB = 0;

  // writable bits; reserved bits read zero
  localparam logic [7:0] BRANCH_MASK_BITS = 8'h7f;
  localparam logic [7:0] CARRIER_BITS = 8'h1f;
  localparam logic [7:0] CHANNEL_BITS = 8'h83;

  // reset values
  localparam logic [7:0] BRANCH_MASK_RST = 8'h00;
  localparam logic [7:0] CARRIER_RST = 8'h00;
  localparam logic [7:0] CHANNEL_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;

  // command channel codes
  localparam logic [1:0] CMD_ALL_CHANNELS = 2'h3;

  // channel count and delay tick
  localparam int NUM_CHAN = 3;
  localparam int NUM_INPUTS = 6;
  localparam int TICK_MS = 12;
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
endpackage : vp_regs_pkg

// ### chan_delay_timer.sv
// one channel's hold-off timer: blocks macro execution for (reload+1) delay ticks
// assumes start is a one-cycle pulse synchronous to hclk
`timescale 1ns/1ns
module chan_delay_timer #(
  parameter int TICK_CYC = vp_regs_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic start,
  input wire logic [7:0] reload,
  // status
  output logic blocked,
  output logic [7:0] remaining
);
  localparam int CW = $clog2(TICK_CYC + 1);
  localparam logic [CW-1:0] PRE_LAST = CW'(TICK_CYC - 1);

  typedef struct packed {
    logic busy;
    logic [7:0] cnt;
    logic [CW-1:0] pre;
  } tmr_t;

  tmr_t st_r;
  tmr_t st_nxt;

  // prescaler restarts at each start so the hold is exact, not off by a tick phase
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = reload;
      st_nxt.pre = '0;
    end else if (st_r.busy) begin
      if (st_r.pre == PRE_LAST) begin
        st_nxt.pre = '0;
        if (st_r.cnt == 8'h00) begin
          st_nxt.busy = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end else begin
        st_nxt.pre = st_r.pre + CW'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign blocked = st_r.busy;
  assign remaining = st_r.cnt;

  // helper: cycles spent blocked since the last start, and the reload taken
  logic [31:0] held_r;
  logic [7:0] taken_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_r <= 32'h0000_0000;
      taken_r <= 8'h00;
    end else if (start) begin
      held_r <= 32'h0000_0000;
      taken_r <= reload;
    end else if (st_r.busy) begin
      held_r <= held_r + 32'h0000_0001;
    end
  end

  sequence s_tick_at_zero;
    st_r.busy && !start && st_r.pre == PRE_LAST && st_r.cnt == 8'h00;
  endsequence

  sequence s_tick_nonzero;
    st_r.busy && !start && st_r.pre == PRE_LAST && st_r.cnt != 8'h00;
  endsequence

  chk_hold_length: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(st_r.busy) |-> held_r == (32'(taken_r) + 32'h0000_0001) * 32'(TICK_CYC))
    else $error("channel hold length is not (reload+1) ticks");

  chk_release_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    s_tick_at_zero |=> !blocked)
    else $error("channel not released after counting down to zero");

  chk_stay_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(blocked) |-> $past(st_r.cnt) == 8'h00)
    else $error("channel released before counter reached zero");

  chk_tick_decrement: assert property (@(posedge hclk) disable iff (!hresetn)
    s_tick_nonzero |=> blocked && remaining == $past(st_r.cnt) - 8'h01)
    else $error("counter did not step down by one on a tick");

  chk_start_loads: assert property (@(posedge hclk) disable iff (!hresetn)
    start |=> blocked && remaining == $past(reload))
    else $error("start did not load the channel reload value");
endmodule : chan_delay_timer

// ### vp_config_regs.sv
// register bank for branch masks, carrier setup, channel control and channel hold timers
// assumes a single AHB-Lite master, single word transfers, hready looped from hreadyout
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
// How it works
// - with busy mask set, branch whenever voice prompt playback is active.
// - each input 0 to 5 has a mask bit branching when that input is high.
// - three-bit carrier field picks the nominal PWM carrier rate.
// - two-bit spread field, 00 no dithering up to 11 strongest.
// - time-division off bit: 0 enables multi-channel operation, 1 disables it.
// - two-bit field routes serial commands to channel 0, 1, 2 or all.
// - each channel has its own eight-bit reload loaded into its down-counter.
// - channel macro execution stays blocked until the tick after its counter reaches zero.
// - config registers reset to zero and are host readable and writable.
module vp_config_regs #(
  parameter int TICK_CYC = vp_regs_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // macro engine condition inputs
  input wire logic playback_active,
  input wire logic [5:0] gpio_in,
  // macro engine channel control
  input wire logic [2:0] chan_start,
  output logic [2:0] chan_blocked,
  output logic branch_taken,
  // carrier generator
  output logic [2:0] carrier_rate_select,
  output logic [1:0] carrier_spread_level,
  // channel routing
  output logic tdm_enable,
  output logic [1:0] command_channel_select,
  output logic [2:0] command_channel_hit
);
  typedef struct packed {
    logic [7:0] branch_mask;
    logic [7:0] carrier;
    logic [7:0] channel;
    logic [2:0][7:0] reload;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic branch;
  } regs_t;

  regs_t st_r;
  regs_t st_nxt;
  logic addr_ok;
  logic [7:0] addr_idx;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [5:0] input_hits;
  logic [2:0] start_gated;

  // only the low byte of each word exists; upper address bits must be zero
  assign addr_idx = haddr[9:2];
  assign addr_ok = hsel && hready && htrans[1] && haddr[31:10] == 22'h00_0000;
  assign wbyte = hwdata[7:0];
  assign input_hits = st_r.branch_mask[5:0] & gpio_in;

  // bus write data phase, address phase capture, read mux and branch decision
  always_comb begin
    st_nxt = st_r;
    rd_byte = 8'h00;
    if (st_r.wr_pend) begin
      case (st_r.wr_idx)
        vp_regs_pkg::IDX_BRANCH_MASK: begin
          st_nxt.branch_mask = wbyte & vp_regs_pkg::BRANCH_MASK_BITS;
        end
        vp_regs_pkg::IDX_CARRIER: begin
          st_nxt.carrier = wbyte & vp_regs_pkg::CARRIER_BITS;
        end
        vp_regs_pkg::IDX_CHANNEL: begin
          st_nxt.channel = wbyte & vp_regs_pkg::CHANNEL_BITS;
        end
        vp_regs_pkg::IDX_CHAN0_RELOAD: st_nxt.reload[0] = wbyte;
        vp_regs_pkg::IDX_CHAN1_RELOAD: st_nxt.reload[1] = wbyte;
        vp_regs_pkg::IDX_CHAN2_RELOAD: st_nxt.reload[2] = wbyte;
        default: st_nxt.wr_idx = st_r.wr_idx; // unmapped or read-only: dropped
      endcase
    end
    st_nxt.wr_pend = addr_ok && hwrite;
    if (addr_ok && hwrite) begin
      st_nxt.wr_idx = addr_idx;
    end
    // read mux looks at the post-write image so write then read back to back is coherent;
    // kept in this process so the read path forms no loop through st_nxt
    case (addr_idx)
      vp_regs_pkg::IDX_BRANCH_MASK: rd_byte = st_nxt.branch_mask;
      vp_regs_pkg::IDX_CARRIER: rd_byte = st_nxt.carrier;
      vp_regs_pkg::IDX_CHANNEL: rd_byte = st_nxt.channel;
      vp_regs_pkg::IDX_CHAN0_RELOAD: rd_byte = st_nxt.reload[0];
      vp_regs_pkg::IDX_CHAN1_RELOAD: rd_byte = st_nxt.reload[1];
      vp_regs_pkg::IDX_CHAN2_RELOAD: rd_byte = st_nxt.reload[2];
      vp_regs_pkg::IDX_CHAN_STATUS: rd_byte = {5'h00, chan_blocked};
      default: rd_byte = 8'h00;
    endcase
    // an out-of-range read still returns zero instead of stale data
    if (hsel && hready && htrans[1] && !hwrite) begin
      st_nxt.rdata = addr_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
    // busy mask and per-input masks all feed one branch condition
    st_nxt.branch = (st_r.branch_mask[vp_regs_pkg::BIT_BRANCH_BUSY] && playback_active)
                    || (|input_hits);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.branch_mask <= vp_regs_pkg::BRANCH_MASK_RST;
      st_r.carrier <= vp_regs_pkg::CARRIER_RST;
      st_r.channel <= vp_regs_pkg::CHANNEL_RST;
      st_r.reload <= {vp_regs_pkg::NUM_CHAN{vp_regs_pkg::RELOAD_RST}};
      st_r.wr_pend <= 1'b0;
      st_r.wr_idx <= 8'h00;
      st_r.rdata <= 32'h0000_0000;
      st_r.branch <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;

  // configuration fields straight from flops
  assign branch_taken = st_r.branch;
  assign carrier_rate_select = st_r.carrier[vp_regs_pkg::CARRIER_RATE_LSB +: 3];
  assign carrier_spread_level = st_r.carrier[vp_regs_pkg::CARRIER_SPREAD_LSB +: 2];
  assign tdm_enable = !st_r.channel[vp_regs_pkg::BIT_TDM_OFF];
  assign command_channel_select = st_r.channel[vp_regs_pkg::CMD_CHAN_LSB +: 2];

  // command routing; with time division off only channel 0 exists, so all collapses to it
  always_comb begin
    if (!tdm_enable) begin
      command_channel_hit = 3'h1;
    end else if (command_channel_select == vp_regs_pkg::CMD_ALL_CHANNELS) begin
      command_channel_hit = 3'h7;
    end else begin
      command_channel_hit = 3'(3'h1 << command_channel_select);
    end
  end

  // one hold timer per channel; channels 1 and 2 ignore starts while time division is off
  genvar gi;
  generate
    for (gi = 0; gi < vp_regs_pkg::NUM_CHAN; gi++) begin : g_chan
      assign start_gated[gi] = chan_start[gi] && (gi == 0 || tdm_enable);
      chan_delay_timer #(
        .TICK_CYC(TICK_CYC)
      ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(start_gated[gi]),
        .reload(st_r.reload[gi]),
        .blocked(chan_blocked[gi]),
        .remaining()
      );
    end
  endgenerate

  sequence s_write_addr(logic [7:0] idx);
    addr_ok && hwrite && addr_idx == idx;
  endsequence

  chk_branch_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.branch_mask[vp_regs_pkg::BIT_BRANCH_BUSY] && playback_active |=> branch_taken)
    else $error("busy branch not taken during playback");

  chk_branch_input: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 branch_taken == ($past(st_r.branch_mask[6] && playback_active)
      || |($past(st_r.branch_mask[5:0]) & $past(gpio_in))))
    else $error("branch output does not match masked conditions");

  chk_carrier_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_write_addr(vp_regs_pkg::IDX_CARRIER) ##1 1'b1
      |=> carrier_rate_select == $past(hwdata[2:0]))
    else $error("carrier rate field not written");

  chk_spread_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_write_addr(vp_regs_pkg::IDX_CARRIER) ##1 1'b1
      |=> carrier_spread_level == $past(hwdata[4:3]))
    else $error("spread field not written");

  chk_tdm_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !tdm_enable && !chan_blocked[1] && chan_start[1] |=> !chan_blocked[1])
    else $error("channel 1 started while time division is off");

  chk_route_all: assert property (@(posedge hclk) disable iff (!hresetn)
    tdm_enable && command_channel_select == 2'h3 |-> command_channel_hit == 3'h7)
    else $error("all-channel select does not hit all channels");

  chk_reload_write: assert property (@(posedge hclk) disable iff (!hresetn)
    s_write_addr(vp_regs_pkg::IDX_CHAN1_RELOAD) ##1 1'b1
      |=> st_r.reload[1] == $past(hwdata[7:0]) && $stable(st_r.reload[0]))
    else $error("channel 1 reload not written independently");

  chk_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && addr_idx == vp_regs_pkg::IDX_CHANNEL
      |=> hrdata == {24'h00_0000, st_r.channel})
    else $error("channel control read does not return register value");

  chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.branch_mask[7] == 1'b0 && st_r.carrier[7:5] == 3'h0 && st_r.channel[6:2] == 5'h00)
    else $error("reserved bits hold a nonzero value");
endmodule : vp_config_regs

// ### ahb_host_model.sv
// host side of the register bus: single word AHB-Lite transfers, one at a time
// assumes hready is looped back from the one slave's hreadyout
`timescale 1ns/1ns
module ahb_host_model (
  // clock
  input wire logic hclk,
  // ahb-lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // hready sampled at rising edges; the bound stands in for a hung slave
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge hclk);
      ok = (hready === 1'b1);
    end
  endtask : wait_ready

  // address phase, then data phase; released lines flip so stale data never looks valid
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output bit ok);
    bit ok2;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready(ok);
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= wr ? wd : ~hwdata;
    wait_ready(ok2);
    rd = hrdata;
    ok = ok & ok2;
    hwdata <= ~wd;
  endtask : xfer
endmodule : ahb_host_model

// ### tb_vp_config_regs.sv
// self-checking bench for the playback config bank
// assumes the host model as bus master and a shortened delay tick
`timescale 1ns/1ns
module tb_vp_config_regs;
  localparam int TICK = 10;
  typedef struct {logic [31:0] a; logic [7:0] w; logic [7:0] r;} row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, playback_active = 1'b0, branch_taken, tdm_enable;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans, carrier_spread_level, command_channel_select;
  logic [2:0] hsize, chan_start = 3'h0, chan_blocked, carrier_rate_select, command_channel_hit;
  logic [5:0] gpio_in = 6'h00;
  int num_errors = 0;
  int cmp_count = 0;
  int cnt;
  // register, value written, value read back (reserved bits, read-only and unmapped)
  row_t rows[9] = '{'{32'h0000_0020, 8'hff, 8'h7f}, '{32'h0000_0024, 8'hff, 8'h1f},
    '{32'h0000_0030, 8'hff, 8'h83}, '{32'h0000_0034, 8'ha5, 8'ha5},
    '{32'h0000_0038, 8'h5a, 8'h5a}, '{32'h0000_003c, 8'hc3, 8'hc3},
    '{32'h0000_0060, 8'hff, 8'h00}, '{32'h0000_0040, 8'hff, 8'h00},
    '{32'h0000_0420, 8'h00, 8'h00}};

  always #4 hclk = ~hclk;

  vp_config_regs #(.TICK_CYC(TICK)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .playback_active(playback_active), .gpio_in(gpio_in), .chan_start(chan_start),
    .chan_blocked(chan_blocked), .branch_taken(branch_taken),
    .carrier_rate_select(carrier_rate_select), .carrier_spread_level(carrier_spread_level),
    .tdm_enable(tdm_enable), .command_channel_select(command_channel_select),
    .command_channel_hit(command_channel_hit));

  ahb_host_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // a transfer that never sees hready ends the run
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] v);
    bit ok;
    host.xfer(wr, a, {24'h00_0000, v}, d, ok);
    if (!ok) begin
      num_errors++;
      stop_test();
    end
  endtask : bus

  // hold one channel and count the blocked cycles
  task automatic hold(input int ch, input logic [7:0] n);
    bus(1'b1, 32'h0000_0034 + 4 * ch, n);
    @(posedge hclk);
    chan_start <= 3'h1 << ch;
    @(posedge hclk);
    chan_start <= 3'h0;
    cnt = 0;
    @(negedge hclk);
    check("others idle", chan_blocked & ~(3'h1 << ch), 3'h0);
    while (chan_blocked[ch] === 1'b1 && cnt < 4000) begin
      cnt++;
      @(negedge hclk);
    end
    check("hold cycles", cnt, (n + 1) * TICK);
  endtask : hold

  initial begin
    repeat (12) @(posedge hclk);
    check("tdm in reset", tdm_enable, 1'b1);
    check("hit in reset", command_channel_hit, 3'h1);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, rows[i].a, 8'h00);
      check("reset value", d, 32'h0000_0000);
    end
    // access kinds: write then read back each row
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 8'h00);
      check("readback", d, {24'h00_0000, rows[i].r});
      check("hresp", hresp, 1'b0);
      check("hready", hreadyout, 1'b1);
    end
    bus(1'b0, 32'h0000_0020, 8'h00);
    check("unmapped write dropped", d, 32'h0000_007f);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 32'h0000_0024, {3'h0, c[1:0], c[2:0]});
      @(negedge hclk);
      check("rate", carrier_rate_select, c[2:0]);
      check("spread", carrier_spread_level, c[1:0]);
    end
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 32'h0000_0030, {6'h00, s[1:0]});
      @(negedge hclk);
      check("cmd select", command_channel_select, s[1:0]);
      check("cmd hit", command_channel_hit, (s == 3) ? 3'h7 : 3'h1 << s);
      check("tdm on", tdm_enable, 1'b1);
    end
    bus(1'b1, 32'h0000_0030, 8'h82);
    @(negedge hclk);
    check("tdm off", tdm_enable, 1'b0);
    check("tdm off hit", command_channel_hit, 3'h1);
    // each mask bit branches on its own cause only
    for (int b = 0; b < 7; b++) begin
      bus(1'b1, 32'h0000_0020, 8'h01 << b);
      for (int on = 1; on >= 0; on--) begin
        @(posedge hclk);
        playback_active <= (b == 6) ? on[0] : !on[0];
        gpio_in <= (on != 0) ? 6'h01 << b : ~(6'h01 << b);
        @(posedge hclk);
        @(negedge hclk);
        check("branch", branch_taken, on[0]);
      end
    end
    // gated start of a second channel while time division is off
    @(posedge hclk);
    chan_start <= 3'h2;
    @(posedge hclk);
    chan_start <= 3'h0;
    @(negedge hclk);
    check("gated start", chan_blocked, 3'h0);
    bus(1'b1, 32'h0000_0030, 8'h00);
    hold(0, 8'h00);
    hold(1, 8'h03);
    hold(2, 8'hff);
    // mid-run reset while channel 2 is held: every register and timer returns to zero
    @(posedge hclk);
    chan_start <= 3'h4;
    @(posedge hclk);
    chan_start <= 3'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("blocked in reset", chan_blocked, 3'h0);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, rows[i].a, 8'h00);
      check("reset value again", d, 32'h0000_0000);
    end
    stop_test();
  end
endmodule : tb_vp_config_regs
